// [command_mode_escape_detector.sv]
`timescale 1ns/10ps
`include "esc_cfg.svh"
module command_mode_escape_detector
  import esc_pkg::*;
#(
  parameter bit TRANSPARENT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  output logic command_mode,
  output logic [3:0] live_rate
);
  import esc_pkg::*;

  // ****************************************
  // Timebase
  // ****************************************
  ms_tick_if tk_if();
  ms_timebase u_tb (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk_if)
  );
  logic tick;
  assign tick = tk_if.ms_tick;

  // ****************************************
  // Registers
  // ****************************************
  logic [11:0] guard_r, guard_nxt;
  logic [7:0] char_r, char_nxt;
  logic [9:0] tmo_r, tmo_nxt;
  logic [3:0] rate_q_r, rate_q_nxt;
  logic [3:0] rate_r, rate_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rdy_r, rdy_nxt;
  logic err_r, err_nxt;
  logic apply_req, leave_req, valid_req;
  mode_type mode_r, mode_nxt;
  logic [11:0] quiet_r, quiet_nxt;
  logic [1:0] seen_r, seen_nxt;
  logic [6:0] sub_r, sub_nxt;
  logic [9:0] idle_r, idle_nxt;
  logic cmdm_r, cmdm_nxt;

  wire acc = psel && penable && !rdy_r;
  wire wr = acc && pwrite;

  function automatic logic known(input logic [11:0] a);
    known = (a == `OFF_GUARD) || (a == `OFF_CHAR) || (a == `OFF_TIMEOUT) ||
            (a == `OFF_RATE) || (a == `OFF_CMD) || (a == `OFF_STATUS);
  endfunction

  always_comb begin
    guard_nxt = guard_r;
    char_nxt = char_r;
    tmo_nxt = tmo_r;
    rate_q_nxt = rate_q_r;
    rate_nxt = rate_r;
    rd_nxt = rd_r;
    rdy_nxt = acc;
    err_nxt = acc && !known(paddr);
    apply_req = 1'b0;
    leave_req = 1'b0;
    valid_req = 1'b0;
    if (wr) begin
      case (paddr)
        `OFF_GUARD: begin
          // Out-of-range values are ignored, setting kept
          if (pwdata[11:0] >= `GUARD_MIN && pwdata[11:0] <= `GUARD_MAX &&
              pwdata[31:12] == 20'h00000) begin
            guard_nxt = pwdata[11:0];
          end
        end
        `OFF_CHAR: char_nxt = pwdata[7:0];
        `OFF_TIMEOUT: begin
          if (pwdata[9:0] >= `TIMEOUT_MIN && pwdata[9:0] <= `TIMEOUT_MAX &&
              pwdata[31:10] == 22'h0) begin
            tmo_nxt = pwdata[9:0];
          end
        end
        `OFF_RATE: rate_q_nxt = pwdata[3:0];
        `OFF_CMD: begin
          apply_req = pwdata[`CMD_APPLY];
          leave_req = pwdata[`CMD_LEAVE];
          valid_req = pwdata[`CMD_VALID];
        end
        default: begin
        end
      endcase
    end
    if (apply_req || leave_req) begin
      rate_nxt = rate_q_r;
    end
    if (acc && !pwrite) begin
      case (paddr)
        `OFF_GUARD: rd_nxt = {20'h00000, guard_r};
        `OFF_CHAR: rd_nxt = {24'h000000, char_r};
        `OFF_TIMEOUT: rd_nxt = {22'h0, tmo_r};
        `OFF_RATE: rd_nxt = {24'h000000, rate_r, rate_q_r};
        `OFF_STATUS: rd_nxt = {30'h0, mode_r};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Escape detection and command mode
  // ****************************************
  wire quiet_ok = (quiet_r >= guard_r);
  wire hit = rx_valid && (rx_char == char_r);

  always_comb begin
    mode_nxt = mode_r;
    seen_nxt = seen_r;
    sub_nxt = sub_r;
    idle_nxt = idle_r;
    quiet_nxt = quiet_r;
    if (tick && !quiet_ok) begin
      quiet_nxt = quiet_r + 12'h001;
    end
    if (rx_valid) begin
      quiet_nxt = 12'h000;
    end
    case (mode_r)
      ST_IDLE: begin
        seen_nxt = 2'b00;
        // Leading silence must be complete before the first char
        if (TRANSPARENT && hit && quiet_ok) begin
          mode_nxt = ST_PRE;
          seen_nxt = 2'b01;
        end
      end
      ST_PRE: begin
        if (rx_valid) begin
          if (hit && seen_r != 2'(`ESC_COUNT)) begin
            seen_nxt = seen_r + 2'b01;
          end else begin
            mode_nxt = ST_IDLE;
          end
        end else if (tick && seen_r != 2'(`ESC_COUNT)) begin
          mode_nxt = ST_IDLE; // Gap between sequence chars
        end else if (seen_r == 2'(`ESC_COUNT)) begin
          mode_nxt = ST_POST;
        end
      end
      ST_POST: begin
        if (rx_valid) begin
          mode_nxt = ST_IDLE;
        end else if (quiet_ok) begin
          mode_nxt = ST_CMD;
          idle_nxt = 10'h000;
          sub_nxt = 7'h00;
        end
      end
      ST_CMD: begin
        if (tick) begin
          sub_nxt = sub_r + 7'h01;
          if (sub_r == 7'(`TICKS_PER_100MS - 1)) begin
            sub_nxt = 7'h00;
            idle_nxt = idle_r + 10'h001;
          end
        end
        if (valid_req) begin
          idle_nxt = 10'h000;
          sub_nxt = 7'h00;
        end
        if (leave_req || idle_r >= tmo_r) begin
          mode_nxt = ST_IDLE;
        end
      end
      default: mode_nxt = ST_IDLE;
    endcase
    cmdm_nxt = (mode_nxt == ST_CMD);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_r <= `RST_GUARD;
      char_r <= `RST_CHAR;
      tmo_r <= `RST_TIMEOUT;
      rate_q_r <= `RST_RATE;
      rate_r <= `RST_RATE;
      rd_r <= 32'h00000000;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      mode_r <= ST_IDLE;
      quiet_r <= 12'h000;
      seen_r <= 2'b00;
      sub_r <= 7'h00;
      idle_r <= 10'h000;
      cmdm_r <= 1'b0;
    end else begin
      guard_r <= guard_nxt;
      char_r <= char_nxt;
      tmo_r <= tmo_nxt;
      rate_q_r <= rate_q_nxt;
      rate_r <= rate_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      mode_r <= mode_nxt;
      quiet_r <= quiet_nxt;
      seen_r <= seen_nxt;
      sub_r <= sub_nxt;
      idle_r <= idle_nxt;
      cmdm_r <= cmdm_nxt;
    end
  end

  assign prdata = rd_r;
  assign pready = rdy_r;
  assign pslverr = err_r;
  assign command_mode = cmdm_r;
  assign live_rate = rate_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ENTER_NEEDS_QUIET: assert property (
    (mode_r == ST_POST && mode_nxt == ST_CMD) |-> quiet_ok && !rx_valid)
    else $error("command mode entered without trailing silence");
  AST_FIRST_NEEDS_QUIET: assert property (
    (mode_r == ST_IDLE && mode_nxt == ST_PRE) |-> quiet_r >= guard_r)
    else $error("escape started without leading silence");
  AST_QUIET_RESTART: assert property (
    rx_valid |=> quiet_r == 12'h000)
    else $error("silence timer not restarted");
  AST_GUARD_RANGE: assert property (
    guard_r >= `GUARD_MIN && guard_r <= `GUARD_MAX)
    else $error("guard time out of range");
  AST_TMO_RANGE: assert property (
    tmo_r >= `TIMEOUT_MIN && tmo_r <= `TIMEOUT_MAX)
    else $error("timeout out of range");
  AST_LEAVE: assert property (
    (mode_r == ST_CMD && leave_req) |=> !command_mode)
    else $error("leave command ignored");
  AST_APPLY: assert property (
    (leave_req || apply_req) |=> live_rate == $past(rate_q_r))
    else $error("queued rate not applied");
  AST_RATE_HELD: assert property (
    !(leave_req || apply_req) |=> $stable(live_rate))
    else $error("live rate changed without apply");
  AST_TIMEOUT: assert property (
    (mode_r == ST_CMD && idle_r >= tmo_r) |=> !command_mode)
    else $error("inactivity timeout ignored");
  AST_CHAR_WR: assert property (
    (wr && paddr == `OFF_CHAR) |=> char_r == $past(pwdata[7:0]))
    else $error("sequence character not stored");

  COV_ENTER: cover property (mode_r == ST_POST && mode_nxt == ST_CMD);
  COV_LEAVE: cover property (mode_r == ST_CMD && leave_req);
  COV_TMO: cover property (mode_r == ST_CMD && idle_r >= tmo_r);
  COV_ABORT: cover property (mode_r == ST_PRE && mode_nxt == ST_IDLE);
endmodule

// [esc_cfg.svh]
`ifndef ESC_CFG_SVH
`define ESC_CFG_SVH
// Register byte offsets
`define OFF_GUARD 12'h000
`define OFF_CHAR 12'h004
`define OFF_TIMEOUT 12'h008
`define OFF_RATE 12'h00c
`define OFF_CMD 12'h010
`define OFF_STATUS 12'h014
// Reset values
`define RST_GUARD 12'h3e8
`define RST_CHAR 8'h2b
`define RST_TIMEOUT 10'h064
`define RST_RATE 4'h3
// Ranges
`define GUARD_MIN 12'h001
`define GUARD_MAX 12'hce4
`define TIMEOUT_MIN 10'h002
`define TIMEOUT_MAX 10'h28f
// Command register bits
`define CMD_APPLY 0
`define CMD_LEAVE 1
`define CMD_VALID 2
// Timebase and escape sequence length
`define TICK_MS_NS 1000000
`define CLK_NS 50
`define TICKS_PER_100MS 100
`define ESC_COUNT 3
`endif

// [esc_pkg.sv]
package esc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_POST = 2'b10,
    ST_CMD = 2'b11
  } mode_type;
endpackage

// [ms_tick_if.sv]
`timescale 1ns/10ps
interface ms_tick_if;
  logic ms_tick;
  modport src(output ms_tick);
  modport dst(input ms_tick);
endinterface

// [ms_timebase.sv]
`timescale 1ns/10ps
`include "esc_cfg.svh"
module ms_timebase #(
  parameter int CYCLES_PER_MS = `TICK_MS_NS / `CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  ms_tick_if.src tk
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 16'h0001;
    if (cnt_r == 16'(CYCLES_PER_MS - 1)) begin
      cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.ms_tick = tick_r;
endmodule

// [serial_host.sv]
`timescale 1ns/10ps
module serial_host (
  input wire logic pclk,
  output logic [7:0] rx_char,
  output logic rx_valid
);
  // ****
  // Host side of the serial stream
  // ****
  initial begin
    rx_char = 8'h00;
    rx_valid = 1'b0;
  end
  // Characters go out on back-to-back cycles; once released the data
  // lines show the inverse so a stale value never looks valid
  task automatic burst(input logic [7:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_char <= c;
      rx_valid <= 1'b1;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_char;
  logic rx_valid, command_mode, err, bad;
  logic [3:0] live_rate;
  logic [44:0] rows [16];
  int err_total = 0;
  int n_compared = 0;
  // ****
  // Design and serial host
  // ****
  command_mode_escape_detector dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_char(rx_char), .rx_valid(rx_valid),
    .command_mode(command_mode), .live_rate(live_rate));
  serial_host host_u (.pclk(pclk), .rx_char(rx_char),
    .rx_valid(rx_valid));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answer is taken at the rising edge at which pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input logic v, input int lim);
    int n;
    n = 0;
    while (command_mode !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
    check({31'h0, command_mode}, {31'h0, v});
  endtask
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // Clock, watchdog, tests
  // ****
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    err_total++;
    conclude();
  end
  initial begin
    rows = '{{1'b0, 12'h000, 32'h3e8}, {1'b0, 12'h004, 32'h2b},
      {1'b0, 12'h008, 32'h64}, {1'b0, 12'h00c, 32'h33},
      {1'b0, 12'h014, 32'h0}, {1'b0, 12'h010, 32'h0},
      {1'b1, 12'h000, 32'h0}, {1'b0, 12'h000, 32'h3e8},
      {1'b1, 12'h000, 32'hce4}, {1'b0, 12'h000, 32'hce4},
      {1'b1, 12'h008, 32'h290}, {1'b0, 12'h008, 32'h64},
      {1'b1, 12'h008, 32'h28f}, {1'b0, 12'h008, 32'h28f},
      {1'b1, 12'h004, 32'hff}, {1'b0, 12'h004, 32'hff}};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({28'h0, live_rate}, 32'h3);
    for (int i = 0; i < 16; i++) begin
      apb(rows[i][44], rows[i][43:32], rows[i][31:0]);
      if (!rows[i][44]) check(rd, rows[i][31:0]);
    end
    $display("Test register table done");
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("Test unmapped done");
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00c, 32'h5);
    repeat (22000) @(posedge pclk);
    host_u.burst(8'hff, 4);
    repeat (22000) begin
      @(negedge pclk);
      if (command_mode !== 1'b0) bad = 1'b1;
    end
    check({31'h0, bad}, 32'h0);
    $display("Test fourth character abort done");
    host_u.burst(8'hff, 3);
    wait_mode(1'b1, 21000);
    check({28'h0, live_rate}, 32'h3);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h3);
    $display("Test escape done");
    apb(1'b1, 12'h010, 32'h2);
    wait_mode(1'b0, 3);
    check({28'h0, live_rate}, 32'h5);
    $display("Test leave command done");
    apb(1'b1, 12'h000, 32'h2);
    host_u.burst(8'h41, 1);
    host_u.burst(8'hff, 3);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h0);
    $display("Test short silence done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({28'h0, live_rate}, 32'h3);
    check({31'h0, command_mode}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h3e8);
    $display("Test mid-run reset done");
    conclude();
  end
endmodule
